// ===== hdl/fbd_pkg.sv
package fbd_pkg;
	// control word field positions
	localparam int CW_PTR_LO    = 0;
	localparam int CW_PTR_W     = 16;
	localparam int CW_TGT_LO    = 16;
	localparam int CW_TGT_W     = 2;
	localparam int CW_CHAIN     = 18;
	localparam int CW_PACE      = 19;
	localparam int CW_INT       = 20;
	localparam int CW_SIZE_LO   = 21;
	localparam int CW_2D        = 23;
	localparam int CW_URGENT    = 24;
	localparam int CW_KIND_LO   = 25;
	// endpoint kinds
	localparam logic [1:0] KIND_INTERNAL = 2'h0;
	localparam logic [1:0] KIND_EXTMEM   = 2'h1;
	localparam logic [1:0] KIND_FLYBY    = 2'h2;
	// item sizes
	localparam logic [1:0] SIZE_WORD  = 2'h1;
	localparam logic [1:0] SIZE_DWORD = 2'h2;
	localparam logic [1:0] SIZE_QUAD  = 2'h3;
	// count and modify word halves
	localparam int CM_CNT_LO = 16;
	localparam int CM_MOD_LO = 0;
	// reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	// channel that flyby chaining reloads
	localparam logic [1:0] FLYBY_CHAN = 2'h0;
	// transfer direction: 0 = device to memory, 1 = memory to device
	localparam logic DIR_IN  = 1'b0;
	localparam logic DIR_OUT = 1'b1;
	// engine states, gray coded along load, run, step, done
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_STEP = 2'b11,
		ST_DONE = 2'b10
	} fbd_state_t;
endpackage

// ===== hdl/fbd_channel.sv
`timescale 1ns/1ps
// Behaviour
// - device-to-memory flyby makes no internal memory access
// - memory-to-device flyby makes no internal access; queue data ignored
// - urgent flag in memory block marks bus transactions urgent
// - two-dimensional mode uses y word beside the x word
// - x word gives word count and address step
// - y word used only in two-dimensional mode, else ignored
// - completion interrupt raised after the whole block moves
// - receiver interrupt bit irrelevant when transmitter has it set
// - per-request mode moves one item per request
// - receiver per-request bit irrelevant when transmitter has it set
// - receiver chain enable irrelevant when transmitter chains
// - inbound memory block uses x count only, ignores step
// - chain pointer used only when chaining, locates next block
// - external or flyby transactions go through outbound queue
module fbd_channel (
	input  wire logic        REF_CLK,      // 250 MHz clock
	input  wire logic        RESET,        // sync reset, high
	input  wire logic        START,        // pulse: load blocks and run
	input  wire logic        DIR,          // fbd_pkg::DIR_IN or DIR_OUT
	input  wire logic [31:0] TX_INDEX,     // transmitter index_address
	input  wire logic [31:0] TX_XCM,       // transmitter x_count_modify
	input  wire logic [31:0] TX_YCM,       // transmitter y_count_modify
	input  wire logic [31:0] TX_CW,        // transmitter control_word
	input  wire logic [31:0] RX_INDEX,     // receiver index_address
	input  wire logic [31:0] RX_XCM,       // receiver x_count_modify
	input  wire logic [31:0] RX_YCM,       // receiver y_count_modify
	input  wire logic [31:0] RX_CW,        // receiver control_word
	input  wire logic        DMA_REQUEST_N,// request pin, async
	input  wire logic        CHAIN_ACK,    // chain fetch done
	input  wire logic [31:0] CHAIN_XCM,    // fetched memory x word
	input  wire logic [31:0] CHAIN_YCM,    // fetched memory y word
	input  wire logic [31:0] CHAIN_INDEX,  // fetched memory index
	input  wire logic [31:0] CHAIN_CW,     // fetched control word
	input  wire logic        OQ_READY,     // outbound queue accepts
	output logic             OQ_VALID,     // outbound queue transaction
	output logic      [31:0] OQ_ADDR,      // external memory address
	output logic             OQ_WRITE,     // 1 = memory write
	output logic             OQ_URGENT,    // urgent access
	output logic       [1:0] OQ_SIZE,      // item_size
	output logic             INT_MEM_REQ,  // internal memory access
	output logic             CHAIN_REQ,    // fetch next block
	output logic      [15:0] CHAIN_PTR,    // chain_pointer to fetch
	output logic       [1:0] CHAIN_TGT,    // chain_target channel
	output logic             BUSY,         // transfer active
	output logic             DONE_IRQ      // one-cycle completion pulse
);
	import fbd_pkg::*;
	default clocking cb_main @(posedge REF_CLK); endclocking
	default disable iff (RESET);

	typedef struct packed {
		logic [1:0]  sync;
		logic        req_d;
		logic        pend;
		fbd_state_t  st;
		logic [31:0] addr;
		logic [31:0] row;
		logic [15:0] xcnt;
		logic [15:0] xstep;
		logic [15:0] xleft;
		logic [15:0] yleft;
		logic [15:0] ystep;
		logic        two_d;
		logic        urgent;
		logic [1:0]  size;
		logic        irq_en;
		logic        per_req;
		logic        chain;
		logic [15:0] ptr;
		logic [1:0]  tgt;
		logic        dir;
		logic        chreq;
		logic        irq;
	} fbd_regs_t;

	fbd_regs_t s_r;
	fbd_regs_t s_nxt;

	// field extraction shared by both control words
	function automatic logic cw_bit(input logic [31:0] cw, input int p);
		cw_bit = cw[p];
	endfunction
	function automatic logic [15:0] cm_cnt(input logic [31:0] cm);
		cm_cnt = cm[CM_CNT_LO +: 16];
	endfunction
	function automatic logic [15:0] cm_mod(input logic [31:0] cm);
		cm_mod = cm[CM_MOD_LO +: 16];
	endfunction

	logic [31:0] mem_x;
	logic [31:0] mem_y;
	logic [31:0] mem_cw;
	logic [31:0] mem_ix;
	logic [31:0] dev_cw;
	logic        req_edge;
	logic        may_go;
	logic        item_go;
	logic        last_x;
	logic        last_y;

	// memory block is the receiver inbound, the transmitter outbound
	assign mem_x  = (DIR == DIR_IN) ? RX_XCM : TX_XCM;
	assign mem_y  = (DIR == DIR_IN) ? RX_YCM : TX_YCM;
	assign mem_cw = (DIR == DIR_IN) ? RX_CW : TX_CW;
	assign mem_ix = (DIR == DIR_IN) ? RX_INDEX : TX_INDEX;
	assign dev_cw = (DIR == DIR_IN) ? TX_CW : RX_CW;

	assign req_edge = s_r.req_d & ~s_r.sync[1];
	// one item per request when paced
	assign may_go  = ~s_r.per_req | s_r.pend;
	assign item_go = (s_r.st == ST_RUN) & may_go & OQ_READY;
	assign last_x  = (s_r.xleft == 16'h0001);
	assign last_y  = ~s_r.two_d | (s_r.yleft <= 16'h0001);

	// all transactions leave through the outbound queue
	assign OQ_VALID  = (s_r.st == ST_RUN) & may_go;
	assign OQ_ADDR   = s_r.addr;
	assign OQ_WRITE  = (s_r.dir == DIR_IN);
	// urgent marking from memory block flag
	assign OQ_URGENT = s_r.urgent;
	assign OQ_SIZE   = s_r.size;
	// no internal memory access in either flyby direction
	assign INT_MEM_REQ = 1'b0;
	assign CHAIN_REQ = s_r.chreq;
	assign CHAIN_PTR = s_r.ptr;
	assign CHAIN_TGT = s_r.tgt;
	assign BUSY      = (s_r.st != ST_IDLE);
	assign DONE_IRQ  = s_r.irq;

	// next-state logic for the whole channel
	always_comb begin
		s_nxt      = s_r;
		s_nxt.sync = {s_r.sync[0], DMA_REQUEST_N};
		s_nxt.req_d = s_r.sync[1];
		s_nxt.irq  = 1'b0;
		if (req_edge) begin
			s_nxt.pend = 1'b1;
		end
		case (s_r.st)
			ST_IDLE: begin
				if (START) begin
					s_nxt.dir    = DIR;
					s_nxt.addr   = mem_ix;
					s_nxt.row    = mem_ix;
					// count and step from x word
					s_nxt.xcnt   = cm_cnt(mem_x);
					s_nxt.xleft  = cm_cnt(mem_x);
					// inbound memory block ignores its step
					s_nxt.xstep  = (DIR == DIR_IN) ? 16'h0001 :
						cm_mod(mem_x);
					// y word only in two-dim mode
					s_nxt.two_d  = cw_bit(mem_cw, CW_2D);
					s_nxt.yleft  = cw_bit(mem_cw, CW_2D) ?
						cm_cnt(mem_y) : 16'h0000;
					s_nxt.ystep  = cw_bit(mem_cw, CW_2D) ?
						cm_mod(mem_y) : 16'h0000;
					s_nxt.urgent = cw_bit(mem_cw, CW_URGENT);
					s_nxt.size   = TX_CW[CW_SIZE_LO +: 2];
					s_nxt.irq_en  = cw_bit(TX_CW, CW_INT) |
						cw_bit(RX_CW, CW_INT);
					s_nxt.per_req = cw_bit(TX_CW, CW_PACE) |
						cw_bit(RX_CW, CW_PACE);
					s_nxt.chain   = cw_bit(TX_CW, CW_CHAIN) |
						cw_bit(RX_CW, CW_CHAIN);
					s_nxt.ptr  = TX_CW[CW_PTR_LO +: CW_PTR_W];
					s_nxt.tgt  = TX_CW[CW_TGT_LO +: CW_TGT_W];
					s_nxt.pend = 1'b0;
					s_nxt.st   = (cm_cnt(mem_x) == 16'h0000) ?
						ST_DONE : ST_RUN;
				end
			end
			ST_RUN: begin
				if (item_go) begin
					// a request is spent per item
					s_nxt.pend = req_edge;
					s_nxt.st   = ST_STEP;
				end
			end
			ST_STEP: begin
				s_nxt.st = ST_RUN;
				if (last_x && last_y) begin
					s_nxt.st = ST_DONE;
				end else if (last_x) begin
					s_nxt.xleft = s_r.xcnt;
					s_nxt.yleft = s_r.yleft - 16'h0001;
					s_nxt.row   = s_r.row + {{16{s_r.ystep[15]}},
						s_r.ystep};
					s_nxt.addr  = s_r.row + {{16{s_r.ystep[15]}},
						s_r.ystep};
				end else begin
					s_nxt.xleft = s_r.xleft - 16'h0001;
					s_nxt.addr  = s_r.addr + {{16{s_r.xstep[15]}},
						s_r.xstep};
				end
			end
			ST_DONE: begin
				if (!s_r.chreq) begin
					s_nxt.irq = s_r.irq_en;
				end
				if (!s_r.chain) begin
					s_nxt.st = ST_IDLE;
				end else if (!s_r.chreq) begin
					s_nxt.chreq = 1'b1;
				end else if (CHAIN_ACK) begin
					s_nxt.chreq   = 1'b0;
					s_nxt.addr    = CHAIN_INDEX;
					s_nxt.row     = CHAIN_INDEX;
					s_nxt.xcnt    = cm_cnt(CHAIN_XCM);
					s_nxt.xleft   = cm_cnt(CHAIN_XCM);
					s_nxt.xstep   = (s_r.dir == DIR_IN) ? 16'h0001 :
						cm_mod(CHAIN_XCM);
					s_nxt.two_d   = cw_bit(CHAIN_CW, CW_2D);
					s_nxt.yleft   = cw_bit(CHAIN_CW, CW_2D) ?
						cm_cnt(CHAIN_YCM) : 16'h0000;
					s_nxt.ystep   = cw_bit(CHAIN_CW, CW_2D) ?
						cm_mod(CHAIN_YCM) : 16'h0000;
					s_nxt.urgent  = cw_bit(CHAIN_CW, CW_URGENT);
					s_nxt.irq_en  = cw_bit(CHAIN_CW, CW_INT);
					s_nxt.per_req = cw_bit(CHAIN_CW, CW_PACE);
					s_nxt.chain   = cw_bit(CHAIN_CW, CW_CHAIN);
					s_nxt.ptr     = CHAIN_CW[CW_PTR_LO +: CW_PTR_W];
					s_nxt.st      = (cm_cnt(CHAIN_XCM) == 16'h0000) ?
						ST_DONE : ST_RUN;
				end
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			s_r      <= '0;
			s_r.sync <= 2'h3;
			s_r.req_d <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	property p_no_internal;
		BUSY |-> !INT_MEM_REQ;
	endproperty
	a_no_internal: assert property (p_no_internal) else $error("internal");
	property p_urgent;
		OQ_VALID |-> (OQ_URGENT == s_r.urgent) && BUSY;
	endproperty
	a_urgent: assert property (p_urgent) else $error("urgent mark wrong");
	property p_paced;
		(OQ_VALID && OQ_READY && s_r.per_req) |-> s_r.pend;
	endproperty
	a_paced: assert property (p_paced) else $error("item without request");
	property p_step_run;
		(OQ_VALID && OQ_READY) |=> !OQ_VALID;
	endproperty
	a_step_run: assert property (p_step_run) else $error("no step gap");
	property p_irq;
		DONE_IRQ |-> $past(s_r.st) == ST_DONE && s_r.st != ST_RUN;
	endproperty
	a_irq: assert property (p_irq) else $error("irq without end");
	property p_irq_once;
		DONE_IRQ |=> !DONE_IRQ;
	endproperty
	a_irq_once: assert property (p_irq_once) else $error("irq too long");
	property p_chain;
		(CHAIN_REQ && CHAIN_ACK) |=> !CHAIN_REQ;
	endproperty
	a_chain: assert property (p_chain) else $error("fetch not closed");
	property p_chain_only;
		CHAIN_REQ |-> s_r.chain;
	endproperty
	a_chain_only: assert property (p_chain_only) else $error("bad fetch");
	property p_inbound_step;
		(BUSY && s_r.dir == DIR_IN) |-> s_r.xstep == 16'h0001;
	endproperty
	a_inbound_step: assert property (p_inbound_step) else $error("step");
	property p_one_d;
		(BUSY && !s_r.two_d) |-> s_r.yleft == 16'h0000;
	endproperty
	a_one_d: assert property (p_one_d) else $error("y used in 1d");
endmodule

// ===== testbench/fbd_mem_model.sv
`timescale 1ns/1ps
module fbd_mem_model
	import fbd_pkg::*;
(
	input  wire logic        REF_CLK,     // clock
	input  wire logic        RESET,       // sync reset, high
	input  wire logic        SLOW,        // 1 = stall the queue at random
	input  wire logic        CHAIN_REQ,   // block fetch request
	input  wire logic [15:0] CHAIN_PTR,   // block to fetch
	output logic             OQ_READY,    // queue accepts
	output logic             CHAIN_ACK,   // fetch done pulse
	output logic      [31:0] CHAIN_INDEX, // fetched index
	output logic      [31:0] CHAIN_XCM,   // fetched x word
	output logic      [31:0] CHAIN_YCM,   // fetched y word
	output logic      [31:0] CHAIN_CW     // fetched control word
);
	logic [7:0] lfsr_r;
	logic [2:0] wait_r;
	logic [31:0] cw_v;
	// next block: one word, step one, word size, no chaining, no interrupt
	assign cw_v = 32'(SIZE_WORD) << CW_SIZE_LO;
	// data lines show garbage outside the acknowledge cycle
	assign CHAIN_INDEX = CHAIN_ACK ? {16'h0, CHAIN_PTR} : ~{16'h0, CHAIN_PTR};
	assign CHAIN_XCM = CHAIN_ACK ? 32'h0001_0001 : 32'hfffe_fffe;
	assign CHAIN_YCM = CHAIN_ACK ? 32'h0000_0000 : 32'hffff_ffff;
	assign CHAIN_CW = CHAIN_ACK ? cw_v : ~cw_v;
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			lfsr_r <= 8'h5a;
			wait_r <= 3'h0;
			OQ_READY <= 1'b0;
			CHAIN_ACK <= 1'b0;
		end else begin
			lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
			OQ_READY <= !SLOW || lfsr_r[0];
			CHAIN_ACK <= 1'b0;
			if (CHAIN_REQ && !CHAIN_ACK)
				wait_r <= wait_r + 3'h1;
			if (wait_r == 3'h3) begin
				CHAIN_ACK <= 1'b1;
				wait_r <= 3'h0;
			end
		end
	end
endmodule

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
	import fbd_pkg::*;
	logic REF_CLK = 0, RESET = 1, START = 0, DIR = 0, REQ_N = 1, SLOW = 0;
	logic [31:0] TX_INDEX = 0, TX_XCM = 0, TX_YCM = 0, TX_CW = 0;
	logic [31:0] RX_INDEX = 0, RX_XCM = 0, RX_YCM = 0, RX_CW = 0;
	logic [31:0] C_IDX, C_XCM, C_YCM, C_CW, OQ_ADDR, base;
	logic [15:0] CHAIN_PTR;
	logic [1:0] OQ_SIZE, CHAIN_TGT;
	logic OQ_READY, OQ_VALID, OQ_WRITE, OQ_URGENT, INT_MEM_REQ, CHAIN_REQ;
	logic CHAIN_ACK, BUSY, DONE_IRQ, ur;
	logic [39:0] expq[$];
	int bad_count = 0, checks = 0, irqs = 0, taken = 0;
	always #2 REF_CLK = ~REF_CLK;
	fbd_channel u_dut (.REF_CLK(REF_CLK), .RESET(RESET), .START(START),
		.DIR(DIR), .TX_INDEX(TX_INDEX), .TX_XCM(TX_XCM), .TX_YCM(TX_YCM),
		.TX_CW(TX_CW), .RX_INDEX(RX_INDEX), .RX_XCM(RX_XCM),
		.RX_YCM(RX_YCM), .RX_CW(RX_CW), .DMA_REQUEST_N(REQ_N),
		.CHAIN_ACK(CHAIN_ACK), .CHAIN_XCM(C_XCM), .CHAIN_YCM(C_YCM),
		.CHAIN_INDEX(C_IDX), .CHAIN_CW(C_CW), .OQ_READY(OQ_READY),
		.OQ_VALID(OQ_VALID), .OQ_ADDR(OQ_ADDR), .OQ_WRITE(OQ_WRITE),
		.OQ_URGENT(OQ_URGENT), .OQ_SIZE(OQ_SIZE), .INT_MEM_REQ(INT_MEM_REQ),
		.CHAIN_REQ(CHAIN_REQ), .CHAIN_PTR(CHAIN_PTR), .CHAIN_TGT(CHAIN_TGT),
		.BUSY(BUSY), .DONE_IRQ(DONE_IRQ));
	fbd_mem_model u_mem (.REF_CLK(REF_CLK), .RESET(RESET), .SLOW(SLOW),
		.CHAIN_REQ(CHAIN_REQ), .CHAIN_PTR(CHAIN_PTR), .OQ_READY(OQ_READY),
		.CHAIN_ACK(CHAIN_ACK), .CHAIN_INDEX(C_IDX), .CHAIN_XCM(C_XCM),
		.CHAIN_YCM(C_YCM), .CHAIN_CW(C_CW));
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// note one expected queue item, word size, direction from DIR
	task automatic note(input logic [31:0] a);
		expq.push_back({1'b0, DIR == DIR_IN, ur, SIZE_WORD, a});
	endtask
	task automatic start;
		@(negedge REF_CLK) START = 1'b1;
		@(negedge REF_CLK) START = 1'b0;
	endtask
	// wait for the block to end, then compare leftovers and interrupts
	task automatic finish(input int n_irq, input string name);
		int i;
		for (i = 0; i < 2000 && BUSY !== 1'b0; i++)
			@(negedge REF_CLK);
		if (i == 2000) begin
			bad_count++;
			report_and_stop();
		end
		// let the closing interrupt pulse be counted first
		repeat (2) @(negedge REF_CLK);
		check(expq.size(), 0);
		check(irqs, n_irq);
		irqs = 0;
		$display("test %s done", name);
	endtask
	task automatic pulse_req;
		@(negedge REF_CLK) REQ_N = 1'b0;
		repeat (2) @(negedge REF_CLK);
		REQ_N = 1'b1;
		repeat (10) @(negedge REF_CLK);
	endtask
	// compare every accepted queue item with the oldest note
	always @(posedge REF_CLK) begin
		if (!RESET && DONE_IRQ === 1'b1)
			irqs++;
		if (!RESET && OQ_VALID === 1'b1 && OQ_READY === 1'b1) begin
			taken++;
			if (expq.size() == 0)
				check(40'h1, 40'h0);
			else
				check({INT_MEM_REQ, OQ_WRITE, OQ_URGENT, OQ_SIZE, OQ_ADDR},
					expq.pop_front());
		end
	end
	initial begin
		void'($urandom(59));
		repeat (12) @(negedge REF_CLK);
		RESET = 1'b0;
		// inbound: memory step ignored, y word ignored, urgent from memory
		// equal sizes, word size, zero device step
		base = $urandom;
		TX_CW = 32'(SIZE_WORD) << CW_SIZE_LO;
		TX_XCM = {16'h3, 16'h0};
		RX_INDEX = base;
		RX_XCM = {16'h3, 16'h5};
		RX_YCM = $urandom;
		RX_CW = TX_CW | (32'h1 << CW_URGENT) | (32'h1 << CW_INT);
		ur = 1'b1;
		for (int k = 0; k < 3; k++)
			note(base + 32'(k));
		start();
		finish(1, "inbound");
		// outbound two-dimensional, interrupt in both blocks, stalling
		DIR = DIR_OUT;
		SLOW = 1'b1;
		ur = 1'b0;
		TX_INDEX = base;
		TX_XCM = {16'h2, 16'h3};
		TX_YCM = {16'h2, 16'h10};
		TX_CW = (32'(SIZE_WORD) << CW_SIZE_LO) | (32'h1 << CW_2D)
			| (32'h1 << CW_INT);
		RX_CW = TX_CW & ~(32'h1 << CW_2D);
		RX_XCM = {16'h4, 16'h0};
		note(base);
		note(base + 32'h3);
		note(base + 32'h10);
		note(base + 32'h13);
		start();
		finish(1, "two_dim");
		// paced: one item per request, none before the first
		SLOW = 1'b0;
		TX_XCM = {16'h2, 16'h1};
		TX_CW = (32'(SIZE_WORD) << CW_SIZE_LO) | (32'h1 << CW_PACE);
		RX_CW = TX_CW;
		taken = 0;
		note(base);
		note(base + 32'h1);
		start();
		repeat (10) @(negedge REF_CLK);
		check(taken, 0);
		pulse_req();
		check(taken, 1);
		pulse_req();
		finish(0, "paced");
		// chained: first block interrupts, fetched block runs next
		// same chaining in both, target channel zero
		TX_CW = (32'(SIZE_WORD) << CW_SIZE_LO) | (32'h1 << CW_CHAIN)
			| (32'h1 << CW_INT) | 32'h0abc;
		RX_CW = TX_CW;
		TX_XCM = {16'h1, 16'h1};
		note(base);
		note(32'h0000_0abc);
		start();
		for (int i = 0; i < 200 && CHAIN_REQ !== 1'b1; i++)
			@(negedge REF_CLK);
		check(CHAIN_REQ, 1'b1);
		check({CHAIN_TGT, CHAIN_PTR}, {FLYBY_CHAN, 16'h0abc});
		finish(1, "chain");
		report_and_stop();
	end
endmodule
